// [current_duty_pwm_encoder.v]
// averages a filtered signed current reading per slot and encodes it as a pwm duty cycle
`timescale 1ns/1ps
`include "pwm_encoder_defines.vh"

module current_duty_pwm_encoder #(
	parameter SAMPLE_WIDTH = 16,
	parameter AVG_LOG2 = 4,
	parameter FULL_SCALE_CURRENT = 1000,
	parameter SLOT_CYCLES = `SLOT_TIME_US * `CLK_FREQ_MHZ,
	parameter HALF_STEP_CYCLES = ((`CLK_FREQ_MHZ * 1000000) / `PWM_FREQ_HZ) / `HALF_STEPS
) (
	// clock and reset
	input wire CLK,
	input wire NRST,
	// filtered current reading, signed, same clock domain
	input wire signed [SAMPLE_WIDTH-1:0] SAMPLE,
	// range variant strap from a pin
	input wire RANGE_HIGH,
	// encoded output
	output reg PWM_OUT,
	output reg [`DUTY_BITS-1:0] DUTY_CODE,
	output reg SLOT_DONE
);
	localparam ACC_WIDTH = SAMPLE_WIDTH + AVG_LOG2;
	localparam TICK_CYCLES = SLOT_CYCLES >> AVG_LOG2;
	localparam integer FS_LOW = FULL_SCALE_CURRENT;
	localparam integer FS_HIGH = FULL_SCALE_CURRENT * `RANGE_FACTOR;
	// rounded gains so full scale lands on the 95.5 / 4.5 percent codes
	localparam integer GAIN_LOW = ((`GAIN_NUM << `GAIN_SHIFT) + (`GAIN_DEN * FS_LOW) / 2) / (`GAIN_DEN * FS_LOW);
	localparam integer GAIN_HIGH = ((`GAIN_NUM << `GAIN_SHIFT) + (`GAIN_DEN * FS_HIGH) / 2) / (`GAIN_DEN * FS_HIGH);

	reg range_meta_q;
	reg range_q;
	reg [31:0] tick_q;
	reg [31:0] tick_d;
	reg [AVG_LOG2-1:0] count_q;
	reg [AVG_LOG2-1:0] count_d;
	reg signed [ACC_WIDTH-1:0] acc_q;
	reg signed [ACC_WIDTH-1:0] acc_d;
	reg [`DUTY_BITS-1:0] pending_q;
	reg [`DUTY_BITS-1:0] pending_d;
	reg [`DUTY_BITS-1:0] duty_q;
	reg [`DUTY_BITS-1:0] duty_d;
	reg pwm_d;
	wire tick_en;
	wire slot_end;
	wire signed [ACC_WIDTH-1:0] acc_sum;
	wire signed [SAMPLE_WIDTH-1:0] avg;
	wire [`RAMP_BITS-1:0] ramp;
	wire period_start;

	// signed reading times the range gain, in duty steps about mid scale
	function signed [SAMPLE_WIDTH+32:0] scale;
		input signed [SAMPLE_WIDTH-1:0] x;
		input high;
		reg signed [SAMPLE_WIDTH+32:0] prod;
		begin
			prod = 0;
			if (high) begin
				prod = x * $signed({1'b0, GAIN_HIGH[31:0]});
			end else begin
				prod = x * $signed({1'b0, GAIN_LOW[31:0]});
			end
			// arithmetic shift floors, so a tiny negative reading already sits one step below mid scale
			scale = prod >>> `GAIN_SHIFT;
		end
	endfunction

	// step offset to duty code, clipped to the code range
	function [`DUTY_BITS-1:0] clip_code;
		input signed [SAMPLE_WIDTH+32:0] off;
		begin
			// truncation keeps the code deterministic: no jitter is added on top of the slot average
			if (off > $signed(`DUTY_MAX - `DUTY_MID)) begin
				clip_code = `DUTY_MAX;
			end else if (off < -$signed({1'b0, `DUTY_MID})) begin
				clip_code = `DUTY_MIN;
			end else begin
				clip_code = `DUTY_MID + off[`DUTY_BITS-1:0];
			end
		end
	endfunction

	// signed reading to duty code
	function [`DUTY_BITS-1:0] to_code;
		input signed [SAMPLE_WIDTH-1:0] x;
		input high;
		begin
			to_code = clip_code(scale(x, high));
		end
	endfunction

	pwm_ramp #(
		.HALF_STEP_CYCLES(HALF_STEP_CYCLES)
	) u_ramp (
		.clk(CLK),
		.nrst(NRST),
		.ramp_q(ramp),
		.period_start_q(period_start)
	);

	assign tick_en = (tick_q == TICK_CYCLES - 1);
	assign slot_end = tick_en && (count_q == {AVG_LOG2{1'b1}});
	assign acc_sum = acc_q + {{AVG_LOG2{SAMPLE[SAMPLE_WIDTH-1]}}, SAMPLE};
	// the sample count per slot is a power of two, so the mean is a plain shift
	assign avg = acc_sum[ACC_WIDTH-1:AVG_LOG2];

	// the variant strap comes from a pin and is resynchronised
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			range_meta_q <= 1'b0;
			range_q <= 1'b0;
		end else begin
			range_meta_q <= RANGE_HIGH;
			range_q <= range_meta_q;
		end
	end

	// slot averaging: equally spaced samples, summed and reduced once per slot
	always @* begin
		tick_d = tick_q + 32'h0000_0001;
		count_d = count_q;
		acc_d = acc_q;
		pending_d = pending_q;
		if (tick_en) begin
			tick_d = 32'h0000_0000;
			count_d = count_q + 1'b1;
			acc_d = acc_sum;
			if (slot_end) begin
				// a result not yet taken by a period start is overwritten by the next slot
				acc_d = {ACC_WIDTH{1'b0}};
				pending_d = to_code(avg, range_q);
			end
		end
	end

	// tick and sample counters
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			tick_q <= 32'h0000_0000;
		end else begin
			tick_q <= tick_d;
		end
	end

	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			count_q <= {AVG_LOG2{1'b0}};
		end else begin
			count_q <= count_d;
		end
	end

	// running sum and the code waiting for the next period
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			acc_q <= {ACC_WIDTH{1'b0}};
		end else begin
			acc_q <= acc_d;
		end
	end

	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			pending_q <= `DUTY_MID;
		end else begin
			pending_q <= pending_d;
		end
	end

	// slot pulse follows the slot's last sample by one cycle
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			SLOT_DONE <= 1'b0;
		end else begin
			SLOT_DONE <= slot_end;
		end
	end

	// the code is swapped only at a period boundary, so a period never mixes codes
	always @* begin
		duty_d = duty_q;
		if (period_start) begin
			duty_d = pending_q;
		end
		// compare in half steps: 2N+1 half steps high gives N and a half steps
		pwm_d = ({duty_q, 1'b1} > ramp);
	end

	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			duty_q <= `DUTY_MID;
		end else begin
			duty_q <= duty_d;
		end
	end

	// the visible code is a copy of the one in force
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			DUTY_CODE <= `DUTY_MID;
		end else begin
			DUTY_CODE <= duty_d;
		end
	end

	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			PWM_OUT <= 1'b0;
		end else begin
			PWM_OUT <= pwm_d;
		end
	end
endmodule // current_duty_pwm_encoder

// [current_duty_pwm_encoder_test.sv]
// self-checking bench for the current duty encoder
`timescale 1ns/1ps
module current_duty_pwm_encoder_test;
	reg CLK = 1'b0;
	reg NRST = 1'b0;
	reg signed [15:0] SAMPLE = 16'h0000;
	reg RANGE_HIGH = 1'b0;
	wire PWM_OUT;
	wire [6:0] DUTY_CODE;
	wire SLOT_DONE;
	wire [6:0] code_seen;
	wire [15:0] period_seen;
	wire [6:0] avg_seen;
	integer err_count = 0;
	integer tests_run = 0;
	integer cycles = 0;
	always #5 CLK = ~CLK;
	current_duty_pwm_encoder #(.SLOT_CYCLES(1600), .HALF_STEP_CYCLES(4)) dut_u (.CLK(CLK), .NRST(NRST),
		.SAMPLE(SAMPLE), .RANGE_HIGH(RANGE_HIGH), .PWM_OUT(PWM_OUT), .DUTY_CODE(DUTY_CODE), .SLOT_DONE(SLOT_DONE));
	host_duty_meter #(.HALF_STEP_CYCLES(4)) host_u (.clk(CLK), .pwm(PWM_OUT), .code_seen(code_seen),
		.period_seen(period_seen), .avg_seen(avg_seen));
	task end_of_test;
		if (err_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task check(input [15:0] seen, input [15:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// two slot pulses make sure a whole slot saw the new value
	task settle(input [15:0] s, input h, input [6:0] e);
		@(posedge CLK);
		#1 SAMPLE = s;
		RANGE_HIGH = h;
		@(posedge SLOT_DONE);
		@(posedge SLOT_DONE);
		repeat (2100) @(posedge CLK);
		#1 check(DUTY_CODE, e);
		check(code_seen, e);
		check(period_seen, 16'h0400);
		// three more falls so all four averaged readings carry the new code
		repeat (3100) @(posedge CLK);
		#1 check(avg_seen, e);
	endtask
	task t_zero;
		settle(16'h0000, 1'b0, 7'h40);
	endtask
	task t_small_neg;
		settle(16'hFFFF, 1'b0, 7'h3F);
	endtask
	task t_pos_full;
		settle(16'h03E8, 1'b0, 7'h7A);
	endtask
	task t_neg_full;
		settle(16'hFC18, 1'b0, 7'h05);
	endtask
	task t_high_range;
		settle(16'h03E8, 1'b1, 7'h45);
	endtask
	task t_clip;
		settle(16'h7FFF, 1'b0, 7'h7F);
	endtask
	always @(posedge CLK) begin
		cycles = cycles + 1;
		if (cycles == 60000) begin
			err_count = err_count + 1;
			end_of_test;
		end
	end
	initial begin
		repeat (16) @(posedge CLK);
		#1 NRST = 1'b1;
		t_zero;
		t_small_neg;
		t_pos_full;
		t_neg_full;
		t_high_range;
		t_clip;
		end_of_test;
	end
endmodule // current_duty_pwm_encoder_test
bind current_duty_pwm_encoder pwm_encoder_checker #(.SLOT_CYCLES(SLOT_CYCLES), .HALF_STEP_CYCLES(HALF_STEP_CYCLES))
	chk_u (.CLK(CLK), .NRST(NRST), .PWM_OUT(PWM_OUT), .DUTY_CODE(DUTY_CODE), .SLOT_DONE(SLOT_DONE));

// [host_duty_meter.sv]
// host side model that measures pwm high time and period
`timescale 1ns/1ps
module host_duty_meter #(
	parameter HALF_STEP_CYCLES = 4
) (
	// pwm line
	input wire clk,
	input wire pwm,
	// measured code, half step removed, and period
	output reg [6:0] code_seen = 7'h00,
	output reg [15:0] period_seen = 16'h0000,
	// code from the mean of the last four high times
	output reg [6:0] avg_seen = 7'h00
);
	reg [15:0] h1_q = 16'h0000;
	reg [15:0] h2_q = 16'h0000;
	reg [15:0] h3_q = 16'h0000;
	reg [15:0] hi_q = 16'h0000;
	reg [15:0] per_q = 16'h0000;
	reg pwm_q = 1'b0;
	always @(posedge clk) begin
		pwm_q <= pwm;
		per_q <= (pwm && !pwm_q) ? 16'h0001 : per_q + 1;
		hi_q <= (pwm && !pwm_q) ? 16'h0001 : hi_q + pwm;
		if (pwm && !pwm_q) begin
			period_seen <= per_q;
		end
		// subtracting one drops the extra half step before halving
		if (!pwm && pwm_q) begin
			code_seen <= (hi_q / HALF_STEP_CYCLES - 1) / 2;
			h1_q <= hi_q;
			h2_q <= h1_q;
			h3_q <= h2_q;
			avg_seen <= ((hi_q + h1_q + h2_q + h3_q) / (4 * HALF_STEP_CYCLES) - 1) / 2;
		end
	end
endmodule // host_duty_meter

// [pwm_encoder_defines.vh]
// constants shared by the current duty encoder files
`ifndef PWM_ENCODER_DEFINES_VH
`define PWM_ENCODER_DEFINES_VH

// clock and timing figures as printed
`define CLK_FREQ_MHZ 100
`define SLOT_TIME_US 6000
`define PWM_FREQ_HZ 160

// duty quantisation
`define DUTY_BITS 7
`define DUTY_LEVELS 128
`define DUTY_MID 7'h40
`define DUTY_MAX 7'h7F
`define DUTY_MIN 7'h00
`define RAMP_BITS 8
`define HALF_STEPS 256

// gain scaling: duty offset = x * 128 / (2.2 * full scale) = x * 640 / (11 * full scale)
`define GAIN_NUM 640
`define GAIN_DEN 11
`define GAIN_SHIFT 16
`define RANGE_FACTOR 10

`endif

// [pwm_encoder_properties.sv]
// port-level timing checks for the current duty encoder
`timescale 1ns/1ps
module pwm_encoder_checker #(
	parameter SLOT_CYCLES = 1600,
	parameter HALF_STEP_CYCLES = 4
) (
	// clock and reset
	input wire CLK,
	input wire NRST,
	// watched outputs
	input wire PWM_OUT,
	input wire [6:0] DUTY_CODE,
	input wire SLOT_DONE
);
	reg [15:0] hc_q;
	reg [15:0] sc_q;
	reg [15:0] cc_q;
	// high time, time since last slot pulse, time since last code change
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			hc_q <= 16'h0000;
			sc_q <= 16'h0000;
			cc_q <= 16'h0000;
		end else begin
			hc_q <= PWM_OUT ? hc_q + 1 : 16'h0000;
			sc_q <= SLOT_DONE ? 16'h0000 : sc_q + 1;
			cc_q <= $changed(DUTY_CODE) ? 16'h0000 : cc_q + 1;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	a_slot_pulse: assert property (SLOT_DONE |=> !SLOT_DONE) else $error("slot pulse too long");
	a_slot_spacing: assert property (SLOT_DONE |-> sc_q >= SLOT_CYCLES - 1) else $error("slot early");
	a_slot_bound: assert property (sc_q <= SLOT_CYCLES + 1) else $error("slot late");
	a_high_time: assert property ($fell(PWM_OUT) |-> hc_q == (2 * DUTY_CODE + 1) * HALF_STEP_CYCLES)
		else $error("high time wrong");
	a_high_bound: assert property (hc_q <= 255 * HALF_STEP_CYCLES) else $error("high too long");
	a_code_stand: assert property ($changed(DUTY_CODE) |-> cc_q >= 256 * HALF_STEP_CYCLES - 1)
		else $error("code changed mid period");
	a_code_rise: assert property ($changed(DUTY_CODE) |-> ##[0:2] $rose(PWM_OUT)) else $error("code off edge");
	a_code_slot: assert property ($changed(DUTY_CODE) |-> sc_q <= 256 * HALF_STEP_CYCLES + 1)
		else $error("code without slot");
	cover property (SLOT_DONE);
	cover property ($changed(DUTY_CODE));
	cover property (DUTY_CODE == 7'h7F);
endmodule // pwm_encoder_checker

// [pwm_ramp.v]
// free-running half-step ramp that paces one pwm period
`timescale 1ns/1ps
`include "pwm_encoder_defines.vh"

module pwm_ramp #(
	parameter HALF_STEP_CYCLES = ((`CLK_FREQ_MHZ * 1000000) / `PWM_FREQ_HZ) / `HALF_STEPS
) (
	// clock and reset
	input wire clk,
	input wire nrst,
	// ramp state
	output reg [`RAMP_BITS-1:0] ramp_q,
	output reg period_start_q
);
	reg [31:0] div_q;
	wire step_en;

	// one-cycle enable per half quantisation step
	assign step_en = (div_q == HALF_STEP_CYCLES - 1);

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_q <= 32'h0000_0000;
			ramp_q <= 8'h00;
			period_start_q <= 1'b0;
		end else begin
			period_start_q <= 1'b0;
			if (step_en) begin
				div_q <= 32'h0000_0000;
				ramp_q <= ramp_q + 8'h01;
				// wrap from the last half step back to zero opens a new period
				if (ramp_q == `HALF_STEPS - 1)
					period_start_q <= 1'b1;
			end else begin
				div_q <= div_q + 32'h0000_0001;
			end
		end
	end
endmodule // pwm_ramp
